/* File: hdl/tas_pkg.sv */
// Purpose: Shared constants for the memory access steering block
// Assumes: APB register bus, 32-bit data
// Notes:   Offsets are byte addresses
package tas_pkg;
   localparam logic [11:0] TAS_CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] TAS_STATUS_OFFSET = 12'h004;
   localparam logic [11:0] TAS_MAP_OFFSET    = 12'h008;
   localparam int          TAS_DTM_BIT       = 2;
   localparam int          TAS_WBUF_BIT      = 3;
   localparam int          TAS_ITM_BIT       = 12;
   localparam logic [31:0] TAS_CTRL_RESET    = 32'h0000_0000;
   localparam logic [31:0] TAS_HIVEC_ADDR    = 32'hFFFF_0000;
   localparam logic [31:0] TAS_LOVEC_ADDR    = 32'h0000_0000;
   localparam logic [31:0] TAS_ITM_BASE_RST  = 32'h0000_0000;
   localparam logic [31:0] TAS_DTM_BASE_RST  = 32'h0080_0000;
   localparam logic [4:0]  TAS_MAP_SHIFT_RST = 5'h10;
   localparam logic [1:0]  TAS_HTRANS_IDLE   = 2'h0;
   localparam logic [1:0]  TAS_HTRANS_NONSEQ = 2'h2;
   typedef enum logic [3:0] {
      TAS_IDLE  = 4'b0001,
      TAS_WAITE = 4'b0010,
      TAS_ADDR  = 4'b0100,
      TAS_DATA  = 4'b1000
   } tas_state_t;
endpackage

/* File: hdl/tas_sync.sv */
// Purpose: Two flip-flop synchroniser for asynchronous levels
// Assumes: Destination is clock
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module tas_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule

/* File: hdl/tas_apb_regs.sv */
// Purpose: APB slave holding control and map registers
// Assumes: Zero wait states, pready always high in access phase
// Notes:   Unmapped addresses read zero and raise pslverr
`timescale 1ns/1ps
module tas_apb_regs
   import tas_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        boot_enable,
   input  wire logic        boot_load,
   input  wire logic [31:0] status_in,
   output logic      [31:0] ctrl_reg,
   output logic      [31:0] map_reg
);
   logic wr_go;
   logic hit;
   assign hit   = paddr == TAS_CTRL_OFFSET || paddr == TAS_STATUS_OFFSET
                  || paddr == TAS_MAP_OFFSET;
   assign wr_go = psel && penable && pwrite;

   // Boot strap loads both enables on reset release
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= TAS_CTRL_RESET;
      end else if (boot_load) begin
         ctrl_reg[TAS_ITM_BIT] <= boot_enable;
         ctrl_reg[TAS_DTM_BIT] <= boot_enable;
      end else if (wr_go && paddr == TAS_CTRL_OFFSET) begin
         ctrl_reg <= pwdata;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         map_reg <= {TAS_DTM_BASE_RST[31:16], 11'h000, TAS_MAP_SHIFT_RST};
      end else if (wr_go && paddr == TAS_MAP_OFFSET) begin
         map_reg <= pwdata;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               TAS_CTRL_OFFSET:   prdata <= ctrl_reg;
               TAS_STATUS_OFFSET: prdata <= status_in;
               TAS_MAP_OFFSET:    prdata <= map_reg;
               default:           prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

/* File: hdl/tas_steer.sv */
// Purpose: Steers core accesses to tight memories or the AHB-Lite port
// Assumes: Bus clock synchronous to clock, enable pulse per bus edge
// Notes:   One access request at a time from the core side
`timescale 1ns/1ps
module tas_steer
   import tas_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rstn,
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Strap pins
   input  wire logic        boot_tight_mem_enable_pin,
   input  wire logic        high_vector_select_pin,
   // Core request
   input  wire logic        core_req,
   input  wire logic        core_instr,
   input  wire logic        core_write,
   input  wire logic        core_bufferable,
   input  wire logic [31:0] core_addr,
   input  wire logic [31:0] core_wdata,
   output logic      [31:0] core_rdata,
   output logic             core_clock_enable,
   output logic      [31:0] boot_vector,
   // Tight memory ports
   output logic             itm_req,
   output logic             dtm_req,
   output logic             tm_write,
   output logic      [31:0] tm_addr,
   output logic      [31:0] tm_wdata,
   input  wire logic        itm_wait,
   input  wire logic        dtm_wait,
   input  wire logic [31:0] itm_rdata,
   input  wire logic [31:0] dtm_rdata,
   // AHB-Lite master
   input  wire logic        bus_clock_enable_in,
   output logic      [31:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   ////////////////////////////////////////////////////////////////////
   logic        rst_meta_reg;
   logic        rst_n;
   logic        boot_load_reg;
   logic [1:0]  pins_sync;
   logic [31:0] ctrl_reg;
   logic [31:0] map_reg;
   logic [31:0] status_w;
   tas_state_t  state_reg;
   tas_state_t  state_next;
   logic        pend_write_reg;
   logic        hit_itm;
   logic        hit_dtm;
   logic        to_tm;
   logic        posted;
   logic        done;
   logic        tm_stall;
   logic        wbuf_full_reg;
   logic [15:0] ahb_count_reg;
   logic [1:0]  tm_rd_reg;

   // Reset release through two flops
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   tas_sync #(.WIDTH(2)) u_pin_sync (
      .clock (clock),
      .rstn  (rst_n),
      .d     ({high_vector_select_pin, boot_tight_mem_enable_pin}),
      .q     (pins_sync)
   );

   // One-shot load of the strap after release, once synchroniser settled
   logic [1:0] boot_cnt_reg;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         boot_cnt_reg  <= 2'h0;
         boot_load_reg <= 1'b0;
         boot_vector   <= TAS_LOVEC_ADDR;
      end else begin
         boot_load_reg <= 1'b0;
         if (boot_cnt_reg != 2'h3) begin
            boot_cnt_reg <= boot_cnt_reg + 2'h1;
            if (boot_cnt_reg == 2'h2) begin
               boot_load_reg <= 1'b1;
               boot_vector   <= pins_sync[1] ? TAS_HIVEC_ADDR
                                             : TAS_LOVEC_ADDR;
            end
         end
      end
   end

   tas_apb_regs u_regs (
      .clock       (clock),
      .rst_n       (rst_n),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .paddr       (paddr),
      .pwdata      (pwdata),
      .prdata      (prdata),
      .pready      (pready),
      .pslverr     (pslverr),
      .boot_enable (pins_sync[0]),
      .boot_load   (boot_load_reg),
      .status_in   (status_w),
      .ctrl_reg    (ctrl_reg),
      .map_reg     (map_reg)
   );

   assign status_w = {ahb_count_reg, 11'h000, wbuf_full_reg,
                      state_reg};

   ////////////////////////////////////////////////////////////////////
   // Region decode; size is a power of two given by map_reg[4:0]
   function automatic logic in_region(input logic [31:0] a,
                                      input logic [31:0] base,
                                      input logic [4:0]  shift);
      logic [31:0] mask;
      mask = 32'hFFFF_FFFF << shift;
      return (a & mask) == (base & mask);
   endfunction

   // Disabled memories are not touched, so contents persist
   assign hit_itm = ctrl_reg[TAS_ITM_BIT] &&
                    in_region(core_addr, TAS_ITM_BASE_RST,
                              map_reg[4:0]);
   assign hit_dtm = ctrl_reg[TAS_DTM_BIT] && !hit_itm &&
                    in_region(core_addr, {map_reg[31:16], 16'h0000},
                              map_reg[4:0]);
   assign to_tm   = hit_itm || hit_dtm;
   assign posted  = core_write && core_bufferable && !core_instr &&
                    ctrl_reg[TAS_WBUF_BIT];
   assign done    = hready && bus_clock_enable_in;
   assign tm_stall = (hit_itm && itm_wait) || (hit_dtm && dtm_wait);

   ////////////////////////////////////////////////////////////////////
   // AHB transfer state machine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         TAS_IDLE: begin
            if (core_req && !to_tm && !(posted && wbuf_full_reg))
               state_next = TAS_WAITE;
         end
         TAS_WAITE: begin
            if (bus_clock_enable_in)
               state_next = TAS_ADDR;
         end
         TAS_ADDR: begin
            if (done)
               state_next = TAS_DATA;
         end
         TAS_DATA: begin
            if (done)
               state_next = TAS_IDLE;
         end
         default: state_next = TAS_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         state_reg <= TAS_IDLE;
      else
         state_reg <= state_next;
   end

   // AHB outputs; held while waiting
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         haddr          <= 32'h0000_0000;
         htrans         <= TAS_HTRANS_IDLE;
         hwrite         <= 1'b0;
         hwdata         <= 32'h0000_0000;
         pend_write_reg <= 1'b0;
      end else begin
         if (state_reg == TAS_IDLE && state_next == TAS_WAITE) begin
            haddr          <= core_addr;
            hwrite         <= core_write;
            hwdata         <= core_wdata;
            pend_write_reg <= posted;
         end
         if (state_reg == TAS_WAITE && bus_clock_enable_in)
            htrans <= TAS_HTRANS_NONSEQ;
         else if (state_reg == TAS_ADDR && done)
            htrans <= TAS_HTRANS_IDLE;
      end
   end

   // One posted write may be outstanding; the core runs on while it completes
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         wbuf_full_reg <= 1'b0;
      else if (state_reg == TAS_DATA && done)
         wbuf_full_reg <= 1'b0;
      else if (state_reg == TAS_IDLE && state_next == TAS_WAITE)
         wbuf_full_reg <= posted;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         ahb_count_reg <= 16'h0000;
      else if (state_reg == TAS_DATA && done)
         ahb_count_reg <= ahb_count_reg + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////
   // Core side: tight memory and posted writes ignore the bus
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         core_clock_enable <= 1'b1;
         core_rdata        <= 32'h0000_0000;
      end else begin
         // Tight read data stands in the cycle after the request
         if (|tm_rd_reg)
            core_rdata <= tm_rd_reg[1] ? itm_rdata : dtm_rdata;
         if (state_reg == TAS_DATA && done) begin
            core_clock_enable <= 1'b1;
            if (!hwrite)
               core_rdata <= hrdata;
         end else if (state_reg == TAS_IDLE) begin
            if (!core_req)
               core_clock_enable <= 1'b1;
            else if (to_tm) begin
               core_clock_enable <= !tm_stall;
            end else if (posted)
               core_clock_enable <= !wbuf_full_reg;
            else
               core_clock_enable <= 1'b0;
         end else begin
            core_clock_enable <= pend_write_reg;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         itm_req  <= 1'b0;
         dtm_req  <= 1'b0;
         tm_write <= 1'b0;
         tm_addr  <= 32'h0000_0000;
         tm_wdata <= 32'h0000_0000;
         tm_rd_reg <= 2'b00;
      end else begin
         tm_rd_reg <= {itm_req && !tm_write, dtm_req && !tm_write};
         itm_req  <= core_req && hit_itm && state_reg == TAS_IDLE;
         dtm_req  <= core_req && hit_dtm && state_reg == TAS_IDLE;
         tm_write <= core_write;
         tm_addr  <= core_addr;
         tm_wdata <= core_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   property p_start_on_enable;
      @(posedge clock) disable iff (!rst_n)
      $rose(htrans[1]) |-> $past(bus_clock_enable_in);
   endproperty
   a_start_on_enable: assert property (p_start_on_enable)
      else $error("AHB transfer started without bus enable");

   property p_hold_addr;
      @(posedge clock) disable iff (!rst_n)
      (state_reg == TAS_ADDR && !done) |=> $stable(haddr) && htrans[1];
   endproperty
   a_hold_addr: assert property (p_hold_addr)
      else $error("AHB address moved during wait");

   property p_release;
      @(posedge clock) disable iff (!rst_n)
      (state_reg == TAS_DATA && done) |=> core_clock_enable;
   endproperty
   a_release: assert property (p_release)
      else $error("Core not released at transfer end");

   property p_stall_unbuffered;
      @(posedge clock) disable iff (!rst_n)
      (state_reg == TAS_ADDR && !pend_write_reg) |=> !core_clock_enable;
   endproperty
   a_stall_unbuffered: assert property (p_stall_unbuffered)
      else $error("Core ran during unbuffered AHB access");

   property p_wait_start;
      @(posedge clock) disable iff (!rst_n)
      (state_reg == TAS_WAITE && !bus_clock_enable_in)
         |=> state_reg == TAS_WAITE;
   endproperty
   a_wait_start: assert property (p_wait_start)
      else $error("Left wait state without bus enable");

   property p_tm_no_bus;
      @(posedge clock) disable iff (!rst_n)
      (state_reg == TAS_IDLE && core_req && to_tm && !tm_stall)
         |=> core_clock_enable && state_reg == TAS_IDLE;
   endproperty
   a_tm_no_bus: assert property (p_tm_no_bus)
      else $error("Tight memory access stalled or used bus");

   property p_itm_off;
      @(posedge clock) disable iff (!rst_n)
      !ctrl_reg[TAS_ITM_BIT] |=> !itm_req;
   endproperty
   a_itm_off: assert property (p_itm_off)
      else $error("Disabled instruction memory selected");

   property p_dtm_off;
      @(posedge clock) disable iff (!rst_n)
      !ctrl_reg[TAS_DTM_BIT] |=> !dtm_req;
   endproperty
   a_dtm_off: assert property (p_dtm_off)
      else $error("Disabled data memory requested");

   property p_boot;
      @(posedge clock) disable iff (!rst_n)
      boot_load_reg |=> ctrl_reg[TAS_ITM_BIT] == $past(pins_sync[0]);
   endproperty
   a_boot: assert property (p_boot)
      else $error("Strap not loaded into enables");

   c_ahb_done: cover property (@(posedge clock) disable iff (!rst_n)
      state_reg == TAS_DATA && done);
   c_tm_hit: cover property (@(posedge clock) disable iff (!rst_n)
      itm_req || dtm_req);
   c_posted: cover property (@(posedge clock) disable iff (!rst_n)
      wbuf_full_reg && core_clock_enable);
endmodule

/* File: sim/tas_far_model.sv */
// Purpose: Far side model: AHB-Lite slave, bus enable, tight SRAMs
// Assumes: Bus clock is the core clock divided by RATIO
// Notes:   Memories are not reset, so contents survive a warm reset
`timescale 1ns/1ps
module tas_far_model
   import tas_pkg::*;
#(
   parameter int RATIO = 32
) (
   input  wire logic        clock,
   input  wire logic [3:0]  waits,
   output logic      [15:0] done_cnt,
   output logic             bus_clock_enable_in,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   output logic             hready,
   output logic      [31:0] hrdata,
   input  wire logic        itm_req,
   input  wire logic        dtm_req,
   input  wire logic        tm_write,
   input  wire logic [31:0] tm_addr,
   input  wire logic [31:0] tm_wdata,
   output logic      [31:0] itm_rdata,
   output logic      [31:0] dtm_rdata
);
   logic [31:0] amem [16];
   logic [31:0] imem [16];
   logic [31:0] dmem [16];
   logic [7:0]  div;
   logic [3:0]  didx;
   logic [3:0]  wcnt;
   logic [31:0] ird;
   logic [31:0] drd;
   logic        dph;
   logic        dwr;
   logic        iv;
   logic        dv;

   initial begin
      {div, didx, wcnt, dph, dwr, iv, dv} = '0;
      {ird, drd, done_cnt} = '0;
      bus_clock_enable_in = 1'b0;
      // Known contents stand for software initialisation
      for (int i = 0; i < 16; i++) begin
         amem[i] = 32'hA000_0000 + 32'(i);
         imem[i] = 32'h1100_0000 + 32'(i);
         dmem[i] = 32'hD200_0000 + 32'(i);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One-cycle enable pulse per bus clock edge
   always @(posedge clock) begin
      div <= (div == 8'(RATIO - 1)) ? 8'h00 : div + 8'h01;
      bus_clock_enable_in <= (div == 8'(RATIO - 2));
   end

   ////////////////////////////////////////////////////////////////////////
   // Slave holds ready low for waits bus cycles of the data phase
   assign hready = !dph || (wcnt == 4'h0);
   // Data not being returned shows the inverse value
   assign hrdata = (dph && !dwr && hready) ? amem[didx] : ~amem[didx];

   always @(posedge clock) begin
      if (bus_clock_enable_in) begin
         if (dph && hready) begin
            if (dwr)
               amem[didx] <= hwdata;
            done_cnt <= done_cnt + 16'h0001;
         end
         if (!hready)
            wcnt <= wcnt - 4'h1;
         if (hready) begin
            dph  <= (htrans == TAS_HTRANS_NONSEQ);
            dwr  <= hwrite;
            didx <= haddr[5:2];
            wcnt <= waits;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Tight SRAMs: read data valid only in the cycle after the request
   always @(posedge clock) begin
      iv <= itm_req && !tm_write;
      dv <= dtm_req && !tm_write;
      if (itm_req && tm_write)
         imem[tm_addr[5:2]] <= tm_wdata;
      if (dtm_req && tm_write)
         dmem[tm_addr[5:2]] <= tm_wdata;
      if (itm_req)
         ird <= imem[tm_addr[5:2]];
      if (dtm_req)
         drd <= dmem[tm_addr[5:2]];
   end
   assign itm_rdata = iv ? ird : ~ird;
   assign dtm_rdata = dv ? drd : ~drd;
endmodule

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the access steering block
// Assumes: Bus clock ratio 32 (160 ns), tight memories without waits
// Notes:   Tight wait inputs are held low
`timescale 1ns/1ps
module tb
   import tas_pkg::*;
;
   localparam int          RATIO = 32;
   localparam int          LIMIT = 30000;
   localparam logic [31:0] MASK  = 32'h0000_1004;
   localparam logic [31:0] A_ITM = 32'h0000_0010;
   localparam logic [31:0] A_DTM = 32'h0080_0010;
   localparam logic [31:0] A_EXT = 32'h4000_0020;
   localparam logic [31:0] D1    = 32'h5A5A_0001;
   localparam logic [31:0] D2    = 32'h3C3C_0002;
   localparam logic [31:0] D3    = 32'h7E7E_0003;
   logic        clock, rstn, psel, penable, pwrite, pready, pslverr;
   logic        boot_pin, hv_pin, core_req, core_instr, core_write;
   logic        core_bufferable, core_clock_enable, itm_req, dtm_req;
   logic        tm_write, bus_clock_enable_in, hwrite, hready, e;
   logic        ph_en, p_cce;
   logic [1:0]  htrans, p_htrans;
   logic [3:0]  waits;
   logic [11:0] paddr;
   logic [15:0] done_cnt, n0;
   logic [31:0] pwdata, prdata, core_addr, core_wdata, core_rdata;
   logic [31:0] boot_vector, tm_addr, tm_wdata, itm_rdata, dtm_rdata;
   logic [31:0] haddr, hwdata, hrdata, p_haddr, r;
   int          miscompares, samples_checked, cycles, icnt, dcnt;
   int          st, i0, d0, age, since, n;

   tas_steer tas_steer_i (.clock(clock), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .boot_tight_mem_enable_pin(boot_pin), .high_vector_select_pin(hv_pin),
      .core_req(core_req), .core_instr(core_instr), .core_write(core_write),
      .core_bufferable(core_bufferable), .core_addr(core_addr),
      .core_wdata(core_wdata), .core_rdata(core_rdata),
      .core_clock_enable(core_clock_enable), .boot_vector(boot_vector),
      .itm_req(itm_req), .dtm_req(dtm_req), .tm_write(tm_write),
      .tm_addr(tm_addr), .tm_wdata(tm_wdata), .itm_wait(1'b0),
      .dtm_wait(1'b0), .itm_rdata(itm_rdata), .dtm_rdata(dtm_rdata),
      .bus_clock_enable_in(bus_clock_enable_in), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata));

   tas_far_model #(.RATIO(RATIO)) tas_far_model_i (.clock(clock),
      .waits(waits), .done_cnt(done_cnt),
      .bus_clock_enable_in(bus_clock_enable_in), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .itm_req(itm_req), .dtm_req(dtm_req),
      .tm_write(tm_write), .tm_addr(tm_addr), .tm_wdata(tm_wdata),
      .itm_rdata(itm_rdata), .dtm_rdata(dtm_rdata));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      $display("Counts: %0d compared, %0d mismatched", samples_checked,
               miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // One core access; st counts the edges the core was held
   task automatic core(input logic ins, input logic w, input logic b,
                       input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      core_req <= 1'b1;
      core_instr <= ins;
      core_write <= w;
      core_bufferable <= b;
      core_addr <= a;
      core_wdata <= d;
      @(posedge clock);
      core_req <= 1'b0;
      st = -1;
      do begin
         @(posedge clock);
         st++;
      end while (core_clock_enable !== 1'b1);
      repeat (2) @(posedge clock);
      r = core_rdata;
   endtask

   task automatic do_reset(input logic boot, input logic hv);
      rstn <= 1'b0;
      boot_pin <= boot;
      hv_pin <= hv;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (8) @(posedge clock);
      chk(32'(core_clock_enable), 32'h1);
      chk(32'(htrans), 32'(TAS_HTRANS_IDLE));
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // Bus monitor and cycle limit
   always @(posedge clock) begin
      if (rstn) begin
         if (htrans == TAS_HTRANS_NONSEQ && p_htrans == TAS_HTRANS_IDLE) begin
            chk(32'(ph_en), 32'h1);
            if (!core_clock_enable)
               chk(32'(since <= RATIO + 1), 32'h1);
         end
         if (core_clock_enable && !p_cce)
            chk(32'(age < 2), 32'h1);
         if (!core_clock_enable && !p_cce)
            chk(haddr, p_haddr);
      end
      p_htrans <= htrans;
      ph_en <= bus_clock_enable_in;
      p_cce <= core_clock_enable;
      p_haddr <= haddr;
      age <= (hready && bus_clock_enable_in) ? 0 : (age < 99 ? age + 1 : age);
      since <= core_clock_enable ? 0 : since + 1;
      icnt <= icnt + int'(itm_req);
      dcnt <= dcnt + int'(dtm_req);
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         conclude();
      end
   end

   initial begin
      {rstn, psel, penable, pwrite, boot_pin, hv_pin, core_req} = '0;
      {core_instr, core_write, core_bufferable, paddr} = '0;
      {pwdata, core_addr, core_wdata} = '0;
      {miscompares, samples_checked, cycles, icnt, dcnt, age, since} = '0;
      {p_htrans, ph_en, p_haddr} = '0;
      p_cce = 1'b1;
      waits = 4'h2;
      do_reset(1'b0, 1'b0);
      chk(boot_vector, TAS_LOVEC_ADDR);
      apb(1'b0, TAS_CTRL_OFFSET, 32'h0000_0000);
      chk(r & MASK, 32'h0000_0000);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk({r[30:0], e}, 32'h0000_0001);
      n0 = done_cnt;
      i0 = icnt;
      core(1'b1, 1'b0, 1'b0, A_ITM, 32'h0000_0000);
      chk(r, 32'hA000_0004);
      chk(32'(st > 0), 32'h1);
      chk(32'(icnt - i0), 32'h0);
      chk(32'(done_cnt - n0), 32'h1);
      $display("test 1 done: strap low sends to bus");
      // Read-modify-write keeps the other bits
      apb(1'b0, TAS_CTRL_OFFSET, 32'h0000_0000);
      apb(1'b1, TAS_CTRL_OFFSET, r | MASK);
      i0 = icnt;
      d0 = dcnt;
      core(1'b0, 1'b1, 1'b0, A_DTM, D1);
      chk(32'(st), 32'h0);
      core(1'b0, 1'b1, 1'b0, A_ITM, D2);
      chk(32'(icnt - i0), 32'h1);
      core(1'b0, 1'b0, 1'b0, A_DTM, 32'h0000_0000);
      chk(r, D1);
      core(1'b1, 1'b0, 1'b0, A_ITM, 32'h0000_0000);
      chk(r, D2);
      chk(32'(dcnt - d0), 32'h2);
      $display("test 2 done: tight memories enabled");
      apb(1'b0, TAS_CTRL_OFFSET, 32'h0000_0000);
      apb(1'b1, TAS_CTRL_OFFSET, r & ~MASK);
      core(1'b0, 1'b0, 1'b0, A_DTM, 32'h0000_0000);
      chk(r, 32'hA000_0004);
      core(1'b1, 1'b0, 1'b0, A_ITM, 32'h0000_0000);
      chk(r, 32'hA000_0004);
      apb(1'b0, TAS_CTRL_OFFSET, 32'h0000_0000);
      apb(1'b1, TAS_CTRL_OFFSET, r | MASK);
      apb(1'b0, TAS_CTRL_OFFSET, 32'h0000_0000);
      chk(r, MASK);
      core(1'b0, 1'b0, 1'b0, A_DTM, 32'h0000_0000);
      chk(r, D1);
      $display("test 3 done: disable and re-enable");
      waits <= 4'h0;
      apb(1'b0, TAS_CTRL_OFFSET, 32'h0000_0000);
      apb(1'b1, TAS_CTRL_OFFSET, r | 32'h0000_0008);
      n0 = done_cnt;
      core(1'b0, 1'b1, 1'b1, A_EXT, D3);
      chk(32'(st), 32'h0);
      n = 0;
      while (done_cnt == n0 && n < 500) begin
         @(posedge clock);
         n++;
      end
      chk(32'(done_cnt - n0), 32'h1);
      core(1'b0, 1'b1, 1'b0, A_EXT + 32'h0000_0004, D2);
      chk(32'(st > 0), 32'h1);
      core(1'b0, 1'b0, 1'b0, A_EXT, 32'h0000_0000);
      chk(r, D3);
      core(1'b0, 1'b0, 1'b0, A_EXT + 32'h0000_0004, 32'h0000_0000);
      chk(r, D2);
      $display("test 4 done: buffered and unbuffered writes");
      do_reset(1'b1, 1'b1);
      chk(boot_vector, TAS_HIVEC_ADDR);
      apb(1'b0, TAS_CTRL_OFFSET, 32'h0000_0000);
      chk(r, MASK);
      d0 = dcnt;
      core(1'b0, 1'b0, 1'b0, A_DTM, 32'h0000_0000);
      chk(r, D1);
      chk(32'(dcnt - d0), 32'h1);
      core(1'b1, 1'b0, 1'b0, A_ITM, 32'h0000_0000);
      chk(r, D2);
      $display("test 5 done: warm reset with strap high");
      conclude();
   end
endmodule
